/* File: design/tcs_params.svh */
// Constants of the seven-channel thermocouple scan block: register numbers,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

// Clock and conversion timing
`define TCS_CLK_HZ 250000000
`define TCS_RATE_60 25
`define TCS_RATE_50 20
`define TCS_TIMER_W 24

// Channels and data
`define TCS_NCH 7
`define TCS_DATA_W 16
`define TCS_CH_AW 3

// Register numbers (Modbus holding register numbers)
`define TCS_REG_SLAVE 16'h9c41
`define TCS_REG_UART 16'h9c42
`define TCS_REG_DELAYS 16'h9c43
`define TCS_REG_VERSION 16'h9c61
`define TCS_REG_STATUS 16'h9c70
`define TCS_REG_CH0 16'h9c71
`define TCS_REG_CH6 16'h9c77
`define TCS_REG_MISC 16'h9c9f
`define TCS_REG_FILTER 16'h9ca0
`define TCS_REG_RANGE0 16'h9ca1
`define TCS_REG_RANGE6 16'h9ca7

// Modbus function codes
`define TCS_FN_READ_HOLD 8'h03
`define TCS_FN_READ_INPUT 8'h04
`define TCS_FN_WRITE_ONE 8'h06
`define TCS_FN_WRITE_MANY 8'h10

// Field limits
`define TCS_SLAVE_MAX 8'hdf
`define TCS_FILTER_MAX 8'h3f
`define TCS_MISC_REJ_BIT 0

// Reset values
`define TCS_RST_SLAVE 8'h01
`define TCS_RST_UART 16'h0035
`define TCS_RST_DELAYS 16'h0003
`define TCS_RST_MISC 1'b0
`define TCS_RST_FILTER 8'h00
`define TCS_RST_LAST_CHAN 3'h6

`endif

/* File: design/tcs_pkg.sv */
// Types of the seven-channel thermocouple scan block.
// Assumes nothing of its surroundings.
package tcs_pkg;

   // Channel range codes; zero disables the channel
   typedef enum logic [7:0] {
      TCS_TC_OFF = 8'h00,
      TCS_TC_J = 8'h01,
      TCS_TC_K = 8'h02,
      TCS_TC_T = 8'h03,
      TCS_TC_E = 8'h04,
      TCS_TC_R = 8'h05,
      TCS_TC_S = 8'h06,
      TCS_TC_B = 8'h07,
      TCS_TC_C = 8'h08
   } tcs_tc_t;

   // Modbus exception answers
   typedef enum logic [7:0] {
      TCS_EXC_NONE = 8'h00,
      TCS_EXC_FUNC = 8'h01,
      TCS_EXC_ADDR = 8'h02,
      TCS_EXC_VALUE = 8'h03
   } tcs_exc_t;

   typedef enum logic [0:0] {
      TCS_ST_WAIT = 1'b0,
      TCS_ST_CONV = 1'b1
   } tcs_scan_st_t;

endpackage : tcs_pkg

/* File: design/tcs_mem_if.sv */
// Port bundle between the scan controller and its result store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`include "tcs_params.svh"
interface tcs_mem_if #(
   parameter int W = `TCS_DATA_W,
   parameter int AW = `TCS_CH_AW
);
   logic we;
   logic [AW-1:0] waddr;
   logic [W-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [W-1:0] rdata;

   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : tcs_mem_if

/* File: design/tcs_result_mem.sv */
// Result store: one word per channel, one write and one read port.
// Assumes a single clock; read data appear one edge after the address.
`timescale 1ns/1ns
`include "tcs_params.svh"
module tcs_result_mem #(
   parameter int W = `TCS_DATA_W,
   parameter int D = `TCS_NCH,
   parameter int AW = `TCS_CH_AW
) (
   input wire logic clk,
   input wire logic reset,
   tcs_mem_if.store m
);
   import tcs_pkg::*;

   typedef struct packed {
      logic [D-1:0][W-1:0] word;
      logic [W-1:0] rdata;
   } tcs_mem_st_t;

   tcs_mem_st_t st_q;
   tcs_mem_st_t st_d;

   if (D < 1 || D > (1 << AW)) begin : g_bad_depth
      $error("tcs_result_mem: depth does not fit the address width");
   end

   // Read sees the old word when the same entry is written in that cycle
   always_comb begin
      st_d = st_q;
      st_d.rdata = '0;
      for (int i = 0; i < D; i++) begin
         if (m.raddr == AW'(i)) begin
            st_d.rdata = st_q.word[i];
         end
         if (m.we && m.waddr == AW'(i)) begin
            st_d.word[i] = m.wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign m.rdata = st_q.rdata;

endmodule : tcs_result_mem

/* File: design/tcs_scan.sv */
// Seven-channel thermocouple scan: slot timer, channel sequencer, converter
// handshake and the Modbus register file behind a register request port.
// Assumes a Modbus RTU engine outside that decodes frames into single
// register requests, and an external 16-bit converter on asynchronous pins.
//
// Overview of operation
// RL1 - Each channel range selects one of eight thermocouple types J K T E R S B C.
// RL2 - Range code zero disables a channel; it never gets a converter slot.
// RL3 - One shared converter with 16-bit results serves all enabled channels.
// RL4 - Twenty-five conversion slots per second in total at 60 Hz rejection, shared by enabled channels.
// RL5 - Slots of disabled channels go to the enabled ones.
// RL6 - Enabled channels are converted in ascending cyclic order, one per slot.
// RL7 - Latest results sit in registers 40049 to 40055, channel 0 lowest.
// RL8 - Result registers answer both function 03 and function 04.
// RL9 - Results are offset binary; zero input reads 0x8000.
// RL10 - Sixty hertz rejection gives 25 slots per second, fifty hertz gives 20.
// RL11 - Reset defaults: slave address 1, 9600 baud, no parity, one stop bit.
// RL12 - Reset defaults: reply delay 3 ms, end-of-query delay 0 ms.
// RL13 - Reset defaults: 60 Hz rejection, both filters zero, type J everywhere.
`timescale 1ns/1ns
`include "tcs_params.svh"
module tcs_scan #(
   parameter int SLOT_CYC_60 = `TCS_CLK_HZ / `TCS_RATE_60,
   parameter int SLOT_CYC_50 = `TCS_CLK_HZ / `TCS_RATE_50,
   parameter logic [15:0] SW_VERSION = 16'h0100
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [7:0] req_func,
   input wire logic [15:0] req_reg,
   input wire logic [15:0] req_wdata,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   output tcs_pkg::tcs_exc_t rsp_exc,
   output logic adc_start,
   output logic [2:0] adc_chan,
   output tcs_pkg::tcs_tc_t adc_tc_type,
   output logic adc_rate_50,
   input wire logic adc_done,
   input wire logic [15:0] adc_data,
   output logic [7:0] cfg_slave_addr,
   output logic [15:0] cfg_uart_setup,
   output logic [15:0] cfg_delays,
   output logic [7:0] cfg_filter
);
   import tcs_pkg::*;

   localparam int TW = `TCS_TIMER_W;
   localparam int NCH = `TCS_NCH;

   if (SLOT_CYC_60 < 4 || SLOT_CYC_50 < 4 ||
       SLOT_CYC_60 >= (1 << TW) || SLOT_CYC_50 >= (1 << TW)) begin : g_bad_slot
      $error("tcs_scan: slot length outside the timer range");
   end

   typedef struct packed {
      tcs_scan_st_t state;
      logic [TW-1:0] timer;
      logic [2:0] cur_chan;
      logic [2:0] last_chan;
      logic [7:0] conv_cnt;
      logic adc_start;
      tcs_tc_t tc_type;
      logic done_s1;
      logic done_s2;
      logic done_s3;
      logic [15:0] data_s1;
      logic [15:0] data_s2;
      logic [7:0] slave;
      logic [15:0] uart;
      logic [15:0] delays;
      logic misc;
      logic [7:0] filter;
      logic [NCH-1:0][7:0] range;
      logic p1_valid;
      logic p1_mem;
      logic [15:0] p1_val;
      tcs_exc_t p1_exc;
      logic rsp_valid;
      logic [15:0] rsp_rdata;
      tcs_exc_t rsp_exc;
   } tcs_scan_reg_t;

   tcs_scan_reg_t st_q;
   tcs_scan_reg_t st_d;
   logic [NCH-1:0] chan_en;
   logic [TW-1:0] slot_lim;
   logic done_edge;

   tcs_mem_if #(.W(`TCS_DATA_W), .AW(`TCS_CH_AW)) mem ();

   tcs_result_mem #(.W(`TCS_DATA_W), .D(NCH), .AW(`TCS_CH_AW)) u_mem (
      .clk(clk),
      .reset(reset),
      .m(mem.store)
   );

   // A channel is enabled whenever its range code is nonzero
   for (genvar g = 0; g < NCH; g++) begin : g_en
      assign chan_en[g] = (st_q.range[g] != TCS_TC_OFF); // [RL2]
   end

   // Next enabled channel after the last one, wrapping after channel 6
   function automatic logic [2:0] tcs_next_chan(input logic [NCH-1:0] en,
                                                input logic [2:0] last);
      int idx;
      logic found;
      logic [2:0] pick;
      idx = 0;
      found = 1'b0;
      pick = last;
      for (int k = 1; k <= NCH; k++) begin
         idx = (int'(last) + k) % NCH;
         if (!found && en[idx]) begin
            pick = 3'(idx); // [RL6] [RL5]
            found = 1'b1;
         end
      end
      return pick;
   endfunction : tcs_next_chan

   assign slot_lim = st_q.misc ? TW'(SLOT_CYC_50) : TW'(SLOT_CYC_60); // [RL10] [RL4]
   assign done_edge = st_q.done_s2 && !st_q.done_s3;

   always_comb begin
      logic slot_tick;
      logic in_data;
      logic in_range;
      logic [2:0] ridx;
      logic fn_ok;
      st_d = st_q;
      slot_tick = 1'b0;
      in_data = (req_reg >= `TCS_REG_CH0) && (req_reg <= `TCS_REG_CH6);
      in_range = (req_reg >= `TCS_REG_RANGE0) && (req_reg <= `TCS_REG_RANGE6);
      ridx = 3'(req_reg - `TCS_REG_RANGE0);
      fn_ok = 1'b0;
      mem.we = 1'b0;
      mem.waddr = st_q.cur_chan;
      mem.wdata = st_q.data_s2;
      mem.raddr = 3'(req_reg - `TCS_REG_CH0);

      // Converter pins cross in through two flops
      st_d.done_s1 = adc_done;
      st_d.done_s2 = st_q.done_s1;
      st_d.done_s3 = st_q.done_s2;
      st_d.data_s1 = adc_data;
      st_d.data_s2 = st_q.data_s1;

      // Slot timer, one tick per conversion slot
      if (st_q.timer >= slot_lim - TW'(1)) begin
         st_d.timer = '0;
         slot_tick = 1'b1; // [RL4] [RL10]
      end else begin
         st_d.timer = st_q.timer + TW'(1);
      end

      st_d.adc_start = 1'b0;
      unique case (st_q.state)
         TCS_ST_WAIT: begin
            if (slot_tick && (chan_en != '0)) begin
               st_d.cur_chan = tcs_next_chan(chan_en, st_q.last_chan); // [RL6] [RL5]
               st_d.tc_type = tcs_tc_t'(st_q.range[st_d.cur_chan]); // [RL1]
               st_d.adc_start = 1'b1;
               st_d.state = TCS_ST_CONV;
            end
         end
         TCS_ST_CONV: begin
            // A slot that ends while the converter is busy is skipped
            if (done_edge) begin
               mem.we = 1'b1; // [RL3] [RL7] [RL9]
               st_d.last_chan = st_q.cur_chan;
               st_d.conv_cnt = st_q.conv_cnt + 8'h01;
               st_d.state = TCS_ST_WAIT;
            end
         end
      endcase

      // Answer stage: registered result two edges after the request
      st_d.rsp_valid = st_q.p1_valid;
      st_d.rsp_exc = st_q.p1_exc;
      st_d.rsp_rdata = st_q.p1_mem ? mem.rdata : st_q.p1_val;

      st_d.p1_valid = req_valid;
      st_d.p1_mem = 1'b0;
      st_d.p1_val = 16'h0000;
      st_d.p1_exc = TCS_EXC_NONE;
      if (req_valid && !req_write) begin
         fn_ok = (req_func == `TCS_FN_READ_HOLD) || (req_func == `TCS_FN_READ_INPUT); // [RL8]
         if (!fn_ok) begin
            st_d.p1_exc = TCS_EXC_FUNC;
         end else if (in_data) begin
            st_d.p1_mem = 1'b1; // [RL7] [RL8]
         end else if (in_range) begin
            st_d.p1_val = {8'h00, st_q.range[ridx]};
         end else begin
            unique case (req_reg)
               `TCS_REG_SLAVE: st_d.p1_val = {8'h00, st_q.slave};
               `TCS_REG_UART: st_d.p1_val = st_q.uart;
               `TCS_REG_DELAYS: st_d.p1_val = st_q.delays;
               `TCS_REG_VERSION: st_d.p1_val = SW_VERSION;
               `TCS_REG_STATUS: st_d.p1_val = {5'h00, st_q.last_chan, st_q.conv_cnt};
               `TCS_REG_MISC: st_d.p1_val = {15'h0000, st_q.misc};
               `TCS_REG_FILTER: st_d.p1_val = {8'h00, st_q.filter};
               default: st_d.p1_exc = TCS_EXC_ADDR;
            endcase
         end
      end else if (req_valid) begin
         fn_ok = (req_func == `TCS_FN_WRITE_ONE) || (req_func == `TCS_FN_WRITE_MANY);
         if (!fn_ok) begin
            st_d.p1_exc = TCS_EXC_FUNC;
         end else if (in_range) begin
            if (req_wdata > 16'(TCS_TC_C)) begin
               st_d.p1_exc = TCS_EXC_VALUE;
            end else begin
               st_d.range[ridx] = req_wdata[7:0]; // [RL1] [RL2]
            end
         end else begin
            unique case (req_reg)
               `TCS_REG_SLAVE: begin
                  if (req_wdata == 16'h0000 || req_wdata > {8'h00, `TCS_SLAVE_MAX}) begin
                     st_d.p1_exc = TCS_EXC_VALUE;
                  end else begin
                     st_d.slave = req_wdata[7:0];
                  end
               end
               `TCS_REG_UART: st_d.uart = req_wdata;
               `TCS_REG_DELAYS: st_d.delays = req_wdata;
               `TCS_REG_MISC: st_d.misc = req_wdata[`TCS_MISC_REJ_BIT]; // [RL10]
               `TCS_REG_FILTER: begin
                  if (req_wdata > {8'h00, `TCS_FILTER_MAX}) begin
                     st_d.p1_exc = TCS_EXC_VALUE;
                  end else begin
                     st_d.filter = req_wdata[7:0];
                  end
               end
               default: st_d.p1_exc = TCS_EXC_ADDR;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '0;
         st_q.state <= TCS_ST_WAIT;
         st_q.last_chan <= `TCS_RST_LAST_CHAN;
         st_q.tc_type <= TCS_TC_J;
         st_q.slave <= `TCS_RST_SLAVE; // [RL11]
         st_q.uart <= `TCS_RST_UART; // [RL11]
         st_q.delays <= `TCS_RST_DELAYS; // [RL12]
         st_q.misc <= `TCS_RST_MISC; // [RL13]
         st_q.filter <= `TCS_RST_FILTER; // [RL13]
         st_q.range <= {NCH{TCS_TC_J}}; // [RL13]
         st_q.p1_exc <= TCS_EXC_NONE;
         st_q.rsp_exc <= TCS_EXC_NONE;
      end else begin
         st_q <= st_d;
      end
   end

   assign rsp_valid = st_q.rsp_valid;
   assign rsp_rdata = st_q.rsp_rdata;
   assign rsp_exc = st_q.rsp_exc;
   assign adc_start = st_q.adc_start;
   assign adc_chan = st_q.cur_chan;
   assign adc_tc_type = st_q.tc_type;
   assign adc_rate_50 = st_q.misc;
   assign cfg_slave_addr = st_q.slave;
   assign cfg_uart_setup = st_q.uart;
   assign cfg_delays = st_q.delays;
   assign cfg_filter = st_q.filter;

   // Cycles since the previous converter start, for the slot spacing check
   logic [TW-1:0] gap_q;
   logic seen_q;
   always_ff @(posedge clk) begin
      if (reset) begin
         gap_q <= '0;
         seen_q <= 1'b0;
      end else if (st_q.adc_start) begin
         gap_q <= '0;
         seen_q <= 1'b1;
      end else if (gap_q != '1) begin
         gap_q <= gap_q + TW'(1);
      end
   end

   a_slot_spacing: assert property (@(posedge clk) disable iff (reset) // [RL4] [RL10]
      (st_q.adc_start && seen_q) |-> (gap_q >= slot_lim - TW'(2)))
      else $error("converter started before a full slot elapsed");

   a_start_enabled: assert property (@(posedge clk) disable iff (reset) // [RL2]
      st_q.adc_start |-> chan_en[st_q.cur_chan])
      else $error("converter started on a disabled channel");

   a_all_on_order: assert property (@(posedge clk) disable iff (reset) // [RL6]
      (st_d.adc_start && chan_en == '1) |=>
      (st_q.cur_chan == ($past(st_q.last_chan) == 3'h6 ? 3'h0 : $past(st_q.last_chan) + 3'h1)))
      else $error("channel order not ascending with all enabled");

   a_type_follows: assert property (@(posedge clk) disable iff (reset) // [RL1]
      st_q.adc_start |-> (8'(st_q.tc_type) == st_q.range[st_q.cur_chan]))
      else $error("converter type differs from channel range");

   a_result_store: assert property (@(posedge clk) disable iff (reset) // [RL7] [RL3]
      (st_q.state == TCS_ST_CONV && done_edge) |->
      (mem.we && mem.wdata == st_q.data_s2) ##1 (st_q.conv_cnt == $past(st_q.conv_cnt) + 8'h01))
      else $error("finished conversion not stored or counted");

   a_read_both_fn: assert property (@(posedge clk) disable iff (reset) // [RL8]
      (req_valid && !req_write && req_reg >= `TCS_REG_CH0 && req_reg <= `TCS_REG_CH6 &&
       (req_func == `TCS_FN_READ_HOLD || req_func == `TCS_FN_READ_INPUT))
      |-> ##2 (rsp_valid && rsp_exc == TCS_EXC_NONE))
      else $error("result read refused");

   a_bad_fn: assert property (@(posedge clk) disable iff (reset) // [RL8]
      (req_valid && !req_write && req_func != `TCS_FN_READ_HOLD &&
       req_func != `TCS_FN_READ_INPUT) |-> ##2 (rsp_valid && rsp_exc == TCS_EXC_FUNC))
      else $error("read with wrong function not refused");

   a_comm_defaults: assert property (@(posedge clk) // [RL11]
      $fell(reset) |-> (cfg_slave_addr == 8'h01 && cfg_uart_setup == 16'h0035))
      else $error("communication defaults wrong after reset");

   a_delay_defaults: assert property (@(posedge clk) // [RL12]
      $fell(reset) |-> (cfg_delays == 16'h0003))
      else $error("delay defaults wrong after reset");

   a_filt_defaults: assert property (@(posedge clk) // [RL13]
      $fell(reset) |-> (!adc_rate_50 && cfg_filter == 8'h00 && st_q.range == {NCH{8'h01}}))
      else $error("filter or range defaults wrong after reset");

endmodule : tcs_scan

/* File: sim/tcs_adc_model.sv */
// Behavioural converter facing the thermocouple scan block.
// Assumes adc_start is a one-cycle pulse on clk with adc_chan valid beside it.
`timescale 1ns/1ns
module tcs_adc_model (
   input wire logic clk,
   input wire logic adc_start,
   input wire logic [2:0] adc_chan,
   input wire logic [7:0] lat,
   output logic adc_done,
   output logic [15:0] adc_data
);
   logic [2:0] ch;

   initial begin
      adc_done = 1'b0;
      adc_data = 16'h0000;
      ch = 3'h0;
   end

   always @(posedge clk) begin
      if (adc_start) begin
         ch = adc_chan;
         repeat (lat) @(posedge clk);
         // Offset binary word; channel 0 reads as a zero input
         adc_data <= 16'h8000 + 16'({13'h0000, ch} * 16'h0101);
         // Data settle four edges ahead of done, held until long after capture
         repeat (4) @(posedge clk);
         adc_done <= 1'b1;
         repeat (6) @(posedge clk);
         adc_done <= 1'b0;
         adc_data <= ~adc_data;
      end
   end
endmodule : tcs_adc_model

/* File: sim/tb.sv */
// Self-checking bench for the thermocouple scan block: scan order, results,
// defaults, refusals, rejection rate and channel disable.
// Assumes the converter model answers every start well within one slot.
`timescale 1ns/1ns
module tb;
   import tcs_pkg::*;
   localparam int S60 = 40;
   localparam int S50 = 50;
   logic clk = 1'b0;
   logic reset;
   logic req_valid, req_write;
   logic [7:0] req_func;
   logic [15:0] req_reg, req_wdata, rsp_rdata, adc_data;
   logic rsp_valid, adc_start, adc_rate_50, adc_done;
   tcs_exc_t rsp_exc;
   tcs_tc_t adc_tc_type;
   logic [2:0] adc_chan;
   logic [7:0] cfg_slave_addr, cfg_filter, lat;
   logic [15:0] cfg_uart_setup, cfg_delays;
   int num_errors = 0;
   int check_count = 0;
   int cyc = 0;
   int last_start = 0;

   always #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   tcs_scan #(.SLOT_CYC_60(S60), .SLOT_CYC_50(S50)) uut (.clk(clk), .reset(reset),
      .req_valid(req_valid), .req_write(req_write), .req_func(req_func),
      .req_reg(req_reg), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_exc(rsp_exc), .adc_start(adc_start),
      .adc_chan(adc_chan), .adc_tc_type(adc_tc_type), .adc_rate_50(adc_rate_50),
      .adc_done(adc_done), .adc_data(adc_data), .cfg_slave_addr(cfg_slave_addr),
      .cfg_uart_setup(cfg_uart_setup), .cfg_delays(cfg_delays), .cfg_filter(cfg_filter));

   tcs_adc_model adc (.clk(clk), .adc_start(adc_start), .adc_chan(adc_chan), .lat(lat),
      .adc_done(adc_done), .adc_data(adc_data));

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // One register request; the answer must come two cycles after it
   task automatic xfer(input logic wr, input logic [7:0] fn, input logic [15:0] rg,
         input logic [15:0] wd, output logic [15:0] rd, output tcs_exc_t ex);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_func <= fn;
      req_reg <= rg;
      req_wdata <= wd;
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (rsp_valid !== 1'b1 && n < 4);
      check(16'(n), 16'h0001, "answer latency");
      rd = rsp_rdata;
      ex = rsp_exc;
   endtask : xfer

   task automatic rd_chk(input logic [7:0] fn, input logic [15:0] rg, input logic [15:0] exp);
      logic [15:0] v;
      tcs_exc_t ex;
      xfer(1'b0, fn, rg, 16'h0000, v, ex);
      check(v, exp, "read data");
      check({8'h00, ex}, 16'h0000, "read status");
   endtask : rd_chk

   task automatic wr_chk(input logic [15:0] rg, input logic [15:0] wd, input tcs_exc_t exp);
      logic [15:0] v;
      tcs_exc_t ex;
      xfer(1'b1, 8'h06, rg, wd, v, ex);
      check({8'h00, ex}, {8'h00, exp}, "write status");
   endtask : wr_chk

   task automatic wait_start(output int gap);
      int n;
      for (n = 0; n < 400; n++) begin
         @(posedge clk);
         #1;
         if (adc_start === 1'b1) begin
            break;
         end
      end
      if (n == 400) begin
         check(16'h0000, 16'h0001, "no converter start");
      end
      gap = cyc - last_start;
      last_start = cyc;
   endtask : wait_start

   task automatic t_order;
      int i, gap, c;
      logic [15:0] v;
      tcs_exc_t ex;
      for (i = 0; i < 9; i++) begin
         wait_start(gap);
         check({13'h0000, adc_chan}, 16'(i % 7), "scan channel");
         check({8'h00, adc_tc_type}, 16'h0001, "range type");
         if (i > 0) begin
            check(16'(gap), 16'(S60), "slot spacing");
            c = (i - 1) % 7;
            rd_chk(i[0] ? 8'h04 : 8'h03, 16'h9c71 + 16'(c), 16'h8000 + 16'(c * 257));
            xfer(1'b0, 8'h03, 16'h9c70, 16'h0000, v, ex);
            check({13'h0000, v[10:8]}, 16'(c), "last channel");
         end
      end
   endtask : t_order

   task automatic t_defaults;
      int i;
      rd_chk(8'h03, 16'h9c41, 16'h0001);
      rd_chk(8'h03, 16'h9c42, 16'h0035);
      rd_chk(8'h03, 16'h9c43, 16'h0003);
      rd_chk(8'h03, 16'h9c9f, 16'h0000);
      rd_chk(8'h03, 16'h9ca0, 16'h0000);
      for (i = 0; i < 7; i++) begin
         rd_chk(8'h03, 16'h9ca1 + 16'(i), 16'h0001);
      end
      check({8'h00, cfg_slave_addr}, 16'h0001, "slave out");
      check(cfg_uart_setup, 16'h0035, "uart out");
      check(cfg_delays, 16'h0003, "delays out");
      check({8'h00, cfg_filter}, 16'h0000, "filter out");
      check({15'h0000, adc_rate_50}, 16'h0000, "rate out");
   endtask : t_defaults

   task automatic t_refuse;
      logic [15:0] v;
      tcs_exc_t ex;
      wr_chk(16'h9c71, 16'h1234, TCS_EXC_ADDR);
      rd_chk(8'h04, 16'h9c71, 16'h8000);
      xfer(1'b0, 8'h06, 16'h9c72, 16'h0000, v, ex);
      check({8'h00, ex}, 16'h0001, "bad read function");
      wr_chk(16'h9ca1, 16'h0009, TCS_EXC_VALUE);
      rd_chk(8'h03, 16'h9ca1, 16'h0001);
      xfer(1'b0, 8'h03, 16'h9c50, 16'h0000, v, ex);
      check({8'h00, ex}, 16'h0002, "unmapped register");
   endtask : t_refuse

   // Setup writes: limits, both write functions, read-only refusals, counter step
   task automatic t_config;
      logic [15:0] v, w;
      tcs_exc_t ex;
      int gap;
      wr_chk(16'h9c41, 16'h0000, TCS_EXC_VALUE);
      wr_chk(16'h9c41, 16'h00e0, TCS_EXC_VALUE);
      xfer(1'b1, 8'h10, 16'h9c41, 16'h0022, v, ex);
      check({8'h00, ex}, 16'h0000, "write many status");
      check(v, 16'h0000, "write answer data");
      check({8'h00, cfg_slave_addr}, 16'h0022, "slave moved");
      wr_chk(16'h9c41, 16'h0001, TCS_EXC_NONE);
      xfer(1'b1, 8'h03, 16'h9c41, 16'h0005, v, ex);
      check({8'h00, ex}, 16'h0001, "bad write function");
      rd_chk(8'h04, 16'h9c41, 16'h0001);
      wr_chk(16'h9c42, 16'h0076, TCS_EXC_NONE);
      check(cfg_uart_setup, 16'h0076, "uart moved");
      wr_chk(16'h9c43, 16'h3003, TCS_EXC_NONE);
      check(cfg_delays, 16'h3003, "delays moved");
      wr_chk(16'h9ca0, 16'h0040, TCS_EXC_VALUE);
      wr_chk(16'h9ca0, 16'h003f, TCS_EXC_NONE);
      check({8'h00, cfg_filter}, 16'h003f, "filter moved");
      wr_chk(16'h9c70, 16'h0000, TCS_EXC_ADDR);
      wr_chk(16'h9c61, 16'h0000, TCS_EXC_ADDR);
      wait_start(gap);
      xfer(1'b0, 8'h03, 16'h9c70, 16'h0000, v, ex);
      wait_start(gap);
      xfer(1'b0, 8'h03, 16'h9c70, 16'h0000, w, ex);
      check({8'h00, w[7:0]}, {8'h00, v[7:0] + 8'h01}, "conversion count");
   endtask : t_config

   task automatic t_rate;
      int gap;
      lat <= 8'd20;
      wr_chk(16'h9c9f, 16'h0001, TCS_EXC_NONE);
      check({15'h0000, adc_rate_50}, 16'h0001, "rate 50");
      repeat (3) wait_start(gap);
      check(16'(gap), 16'(S50), "slot spacing 50");
      wr_chk(16'h9c9f, 16'h0000, TCS_EXC_NONE);
      check({15'h0000, adc_rate_50}, 16'h0000, "rate 60");
      repeat (3) wait_start(gap);
      check(16'(gap), 16'(S60), "slot spacing 60");
      lat <= 8'd2;
   endtask : t_rate

   task automatic t_disable;
      int i, t, gap, n;
      logic [2:0] prev;
      for (i = 0; i < 7; i++) begin
         if (i != 0 && i != 2) begin
            wr_chk(16'h9ca1 + 16'(i), 16'h0000, TCS_EXC_NONE);
         end
      end
      wait_start(gap);
      prev = adc_chan;
      for (i = 0; i < 4; i++) begin
         wait_start(gap);
         check({13'h0000, adc_chan}, (prev == 3'h0) ? 16'h0002 : 16'h0000, "skip off");
         check(16'(gap), 16'(S60), "slot reuse");
         prev = adc_chan;
      end
      for (t = 1; t < 9; t++) begin
         wr_chk(16'h9ca3, 16'(t), TCS_EXC_NONE);
         for (n = 0; n < 3; n++) begin
            wait_start(gap);
            if (adc_chan === 3'h2) begin
               break;
            end
         end
         check({8'h00, adc_tc_type}, 16'(t), "range type");
      end
      wr_chk(16'h9ca3, 16'h0000, TCS_EXC_NONE);
      wr_chk(16'h9ca1, 16'h0000, TCS_EXC_NONE);
      n = 0;
      for (i = 0; i < 3 * S60; i++) begin
         @(posedge clk);
         #1;
         n += int'(adc_start === 1'b1);
      end
      check(16'(n), 16'h0000, "starts with all off");
   endtask : t_disable

   initial begin
      reset = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_func = 8'h00;
      req_reg = 16'h0000;
      req_wdata = 16'h0000;
      lat = 8'd2;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_order();
      t_defaults();
      t_refuse();
      t_config();
      t_rate();
      t_disable();
      close_out();
   end

   // Whole run needs well under 5000 cycles
   initial begin
      #80000;
      num_errors++;
      $display("BAD t=%0t watchdog expired", $time);
      close_out();
   end
endmodule : tb
